// ---- design/mds_defs.svh ----
// constants shared by the motor driver serial slave
`ifndef MDS_DEFS_SVH
`define MDS_DEFS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define MDS_FRAME_BITS 40
`define MDS_ADDR_W 7
`define MDS_DATA_W 24
`define MDS_CRC_W 8
`define MDS_HDR_W 32
`define MDS_CNT_W 9

// ----------------------------------------------------------------
// protocol values
// ----------------------------------------------------------------
`define MDS_DIR_READ 1'b0
`define MDS_DIR_WRITE 1'b1
`define MDS_CRC_POLY 8'h1d
`define MDS_CRC_INIT 8'h00
`define MDS_MAX_FRAMES 8
`define MDS_NUM_REGS 16

// ----------------------------------------------------------------
// pin synchroniser lanes
// ----------------------------------------------------------------
`define MDS_PIN_SCLK 0
`define MDS_PIN_CS 1
`define MDS_PIN_SDI 2
`define MDS_PIN_SLEEP 3
`define MDS_PIN_N 4
`define MDS_PIN_IDLE 4'b1010

`endif

// ---- design/mds_pkg.sv ----
// types shared by the motor driver serial slave
`include "mds_defs.svh"

package mds_pkg;

  // one 40-bit frame, msb first on the wire
  typedef struct packed {
    logic dir;
    logic [`MDS_ADDR_W-1:0] addr;
    logic [`MDS_DATA_W-1:0] data;
    logic [`MDS_CRC_W-1:0] crc;
  } mds_frame_s;

  // accepted register access handed to the motor logic
  typedef struct packed {
    logic valid;
    logic write;
    logic [`MDS_ADDR_W-1:0] addr;
    logic [`MDS_DATA_W-1:0] data;
  } mds_cmd_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_XFER = 2'h1,
    ST_EXEC = 2'h3
  } mds_state_e;

endpackage

// ---- design/mds_crc8.sv ----
// crc-8 over a header word, left shifting, msb first
`timescale 1ns/1ps
`default_nettype none
`include "mds_defs.svh"

module mds_crc8 #(
  parameter int DATA_W = `MDS_HDR_W
) (
  // data in
  input wire logic [DATA_W-1:0] data_i,
  // checksum out
  output logic [`MDS_CRC_W-1:0] crc_o
);

  always_comb begin
    logic [`MDS_CRC_W-1:0] c;
    logic fb;
    c = `MDS_CRC_INIT;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      fb = c[`MDS_CRC_W-1] ^ data_i[i];
      c = {c[`MDS_CRC_W-2:0], 1'b0} ^ (fb ? `MDS_CRC_POLY : `MDS_CRC_INIT);
    end
    crc_o = c;
  end

endmodule

`default_nettype wire

// ---- design/mds_spi_slave.sv ----
// serial slave of the dual h-bridge motor driver
// How it works
// R01 - sleep input low puts the block to sleep; high means normal work
// R02 - asleep: only the sleep input lives; link, oscillator, outputs are off
// R03 - logic runs from the free-running internal oscillator, no trigger needed
// R04 - the slave joins a transfer only while chip select is low
// R05 - commands are decided and executed only at chip select rising edge
// R06 - serial output is high impedance whenever chip select is high
// R07 - master changes serial input on each rising serial clock edge
// R08 - serial input sampled on falling clock edges, msb first
// R09 - serial output updated on each rising serial clock edge
// R10 - reply frames leave msb first
// R11 - frame is 40 bits: direction, address, 24 data bits, crc
// R12 - in parallel wiring the master gives each frame its own select
// R13 - daisy chains of up to eight frames share one select period
// R14 - direction bit zero marks a read of the addressed register
// R15 - data bits of a read request are ignored
// R16 - master computes its crc over bits 39 down to 8
// R17 - read data is returned in the frame after the request
// R18 - a read with a bad crc is not carried out
// R19 - reply bit 39 flags an error in the previous frame
// R20 - reply echoes the address of the request
// R21 - reply crc covers error flag, address and data
// R22 - a good write stores the data and the reply returns it
// R23 - crc polynomial 0x1d, left shift, zero initial value
// R24 - bad clock count or unknown address: nothing runs, error flagged
// R25 - a finished frame is brought into the oscillator domain before use
`timescale 1ns/1ps
`default_nettype none
`include "mds_defs.svh"

module mds_spi_slave
  import mds_pkg::*;
#(
  parameter int NUM_REGS = `MDS_NUM_REGS,
  parameter int MAX_FRAMES = `MDS_MAX_FRAMES
) (
  // clock and reset (clock is the internal oscillator)
  input wire logic clk_i,
  input wire logic rst_b_i,
  // power control pin
  input wire logic sleep_control_n_i,
  // serial link pins
  input wire logic sclk_i,
  input wire logic chip_select_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // user side
  output logic internal_oscillator_en_o,
  output mds_cmd_s cmd_o,
  output logic frame_err_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [`MDS_PIN_N-1:0] pin_meta_ff;
  logic [`MDS_PIN_N-1:0] pin_sync_ff;
  logic [`MDS_PIN_N-1:0] pin_prev_ff;
  logic awake;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic sdi_s;
  logic cs_n_s;

  // every pin crosses two flops; the edge finders only see the second
  always_ff @(posedge clk_i) begin // see R25
    if (!rst_b_i) begin
      pin_meta_ff <= `MDS_PIN_IDLE;
      pin_sync_ff <= `MDS_PIN_IDLE;
      pin_prev_ff <= `MDS_PIN_IDLE;
    end else begin
      pin_meta_ff <= {sleep_control_n_i, sdi_i, chip_select_n_i, sclk_i};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // sleep gates the whole link; only the sleep lane keeps running
  assign awake = pin_sync_ff[`MDS_PIN_SLEEP]; // see R01
  assign cs_n_s = pin_sync_ff[`MDS_PIN_CS];
  assign sdi_s = pin_sync_ff[`MDS_PIN_SDI];
  assign sclk_rise = awake && !cs_n_s
                     && pin_sync_ff[`MDS_PIN_SCLK] && !pin_prev_ff[`MDS_PIN_SCLK];
  assign sclk_fall = awake && !cs_n_s
                     && !pin_sync_ff[`MDS_PIN_SCLK] && pin_prev_ff[`MDS_PIN_SCLK];
  assign cs_fall = awake && !cs_n_s && pin_prev_ff[`MDS_PIN_CS]; // see R04
  assign cs_rise = awake && cs_n_s && !pin_prev_ff[`MDS_PIN_CS]; // see R05

  // clk_i stands in for the oscillator; it runs whenever awake
  assign internal_oscillator_en_o = awake; // see R03

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  mds_state_e state_ff;
  logic [`MDS_FRAME_BITS-1:0] sreg_ff;
  logic [`MDS_CNT_W-1:0] cnt_ff;
  logic sdo_ff;
  logic [`MDS_HDR_W-1:0] reply_hdr_ff;
  logic [`MDS_DATA_W-1:0] regs_ff [NUM_REGS];
  logic err_ff;
  mds_cmd_s cmd_ff;

  mds_frame_s rx;
  logic [`MDS_CRC_W-1:0] rx_crc;
  logic [`MDS_CRC_W-1:0] reply_crc;
  logic [`MDS_FRAME_BITS-1:0] reply_frame;
  logic cnt_good;
  logic crc_good;
  logic addr_good;
  logic frame_good;
  logic [`MDS_DATA_W-1:0] reg_rd;
  logic [`MDS_DATA_W-1:0] nxt_reply_data;

  // the total clock count may cover one to MAX_FRAMES whole frames
  function automatic logic count_ok(input logic [`MDS_CNT_W-1:0] c);
    logic ok;
    ok = 1'b0;
    for (int k = 1; k <= MAX_FRAMES; k++) begin
      if (c == `MDS_CNT_W'(k * `MDS_FRAME_BITS)) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  function automatic logic addr_ok(input logic [`MDS_ADDR_W-1:0] a);
    return 32'(a) < NUM_REGS;
  endfunction

  // in a chain the last 40 bits shifted in are this device's own frame
  assign rx = mds_frame_s'(sreg_ff); // see R11

  mds_crc8 #(
    .DATA_W(`MDS_HDR_W)
  ) u_rx_crc (
    .data_i(sreg_ff[`MDS_FRAME_BITS-1:`MDS_CRC_W]),
    .crc_o(rx_crc)
  );

  mds_crc8 #(
    .DATA_W(`MDS_HDR_W)
  ) u_tx_crc (
    .data_i(reply_hdr_ff),
    .crc_o(reply_crc)
  );

  assign reply_frame = {reply_hdr_ff, reply_crc}; // see R21
  assign cnt_good = count_ok(cnt_ff); // see R24
  assign crc_good = rx_crc == rx.crc; // see R23
  assign addr_good = addr_ok(rx.addr); // see R24
  assign frame_good = cnt_good && crc_good && addr_good;
  assign reg_rd = addr_good ? regs_ff[rx.addr[$clog2(NUM_REGS)-1:0]] : '0;

  // write replies with the stored value, read with the current one
  always_comb begin
    if (frame_good && rx.dir == `MDS_DIR_WRITE) begin // see R22
      nxt_reply_data = rx.data;
    end else begin
      nxt_reply_data = reg_rd; // see R17
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !awake) begin // see R02
      state_ff <= ST_IDLE;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (cs_fall) begin // see R04
            state_ff <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (cs_rise) begin // see R05
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // shift register and bit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !awake) begin
      sreg_ff <= '0;
    end else if (state_ff == ST_IDLE && cs_fall) begin
      sreg_ff <= reply_frame; // see R10
    end else if (state_ff == ST_XFER && sclk_fall) begin
      sreg_ff <= {sreg_ff[`MDS_FRAME_BITS-2:0], sdi_s}; // see R08
    end
  end

  // counting saturates just above the longest chain so overruns stay bad
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !awake) begin
      cnt_ff <= '0;
    end else if (state_ff == ST_IDLE && cs_fall) begin
      cnt_ff <= '0;
    end else if (state_ff == ST_XFER && sclk_fall
                 && cnt_ff <= `MDS_CNT_W'(MAX_FRAMES * `MDS_FRAME_BITS)) begin
      cnt_ff <= cnt_ff + `MDS_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // first bit is presented at select fall so it is ready before any edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !awake) begin
      sdo_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && cs_fall) begin
      sdo_ff <= reply_frame[`MDS_FRAME_BITS-1];
    end else if (state_ff == ST_XFER && sclk_rise) begin
      sdo_ff <= sreg_ff[`MDS_FRAME_BITS-1]; // see R09
    end
  end

  assign sdo_o = sdo_ff;
  assign sdo_oe_o = awake && !cs_n_s; // see R06

  // ----------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_ff[i] <= '0;
      end
    end else if (state_ff == ST_EXEC && frame_good && rx.dir == `MDS_DIR_WRITE) begin
      regs_ff[rx.addr[$clog2(NUM_REGS)-1:0]] <= rx.data; // see R22
    end
  end

  // read data field is never looked at for a read request
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !awake) begin
      cmd_ff <= '0;
    end else if (state_ff == ST_EXEC) begin
      cmd_ff.valid <= frame_good; // see R18
      cmd_ff.write <= rx.dir; // see R14
      cmd_ff.addr <= rx.addr;
      cmd_ff.data <= (rx.dir == `MDS_DIR_WRITE) ? rx.data : '0; // see R15
    end else begin
      cmd_ff.valid <= 1'b0;
    end
  end

  // the reply header is built here and shifted out in the next frame
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !awake) begin
      reply_hdr_ff <= '0;
    end else if (state_ff == ST_EXEC) begin
      reply_hdr_ff <= {!frame_good, rx.addr, nxt_reply_data}; // see R19 see R20
    end
  end

  // level error indicator, cleared by the next good frame
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !awake) begin
      err_ff <= 1'b0;
    end else if (state_ff == ST_EXEC) begin
      err_ff <= !frame_good; // see R24
    end
  end

  assign cmd_o = cmd_ff;
  assign frame_err_o = err_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_sleep_quiet;
    @(posedge clk_i) disable iff (!rst_b_i)
    !pin_sync_ff[`MDS_PIN_SLEEP] |-> !sdo_oe_o && !internal_oscillator_en_o ##1 !cmd_o.valid;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("link active while asleep"); // see R02

  property p_wake;
    @(posedge clk_i) disable iff (!rst_b_i)
    $rose(pin_sync_ff[`MDS_PIN_SLEEP]) |-> internal_oscillator_en_o && state_ff == ST_IDLE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not restart idle"); // see R01

  property p_hiz;
    @(posedge clk_i) disable iff (!rst_b_i)
    chip_select_n_i ##1 chip_select_n_i |=> !sdo_oe_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("sdo driven with select high"); // see R06

  property p_exec_at_rise;
    @(posedge clk_i) disable iff (!rst_b_i)
    cmd_o.valid |-> $past(state_ff, 1) == ST_EXEC && $past(cs_rise, 2);
  endproperty
  a_exec_at_rise: assert property (p_exec_at_rise) else $error("command outside select rise"); // see R05

  property p_shift_in;
    @(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_XFER && sclk_fall |=> sreg_ff[0] == $past(sdi_s)
      && sreg_ff[`MDS_FRAME_BITS-1:1] == $past(sreg_ff[`MDS_FRAME_BITS-2:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("bad serial sample"); // see R08

  property p_sdo_update;
    @(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_XFER && sclk_rise |=> sdo_o == $past(sreg_ff[`MDS_FRAME_BITS-1]) ##1 $stable(sdo_o);
  endproperty
  a_sdo_update: assert property (p_sdo_update) else $error("sdo not updated on rise"); // see R09

  property p_bad_crc;
    @(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_EXEC && !crc_good |=> !cmd_o.valid && frame_err_o && reply_hdr_ff[`MDS_HDR_W-1];
  endproperty
  a_bad_crc: assert property (p_bad_crc) else $error("bad crc frame executed"); // see R18

  property p_bad_count;
    @(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_EXEC && (!cnt_good || !addr_good) |=> !cmd_o.valid && frame_err_o;
  endproperty
  a_bad_count: assert property (p_bad_count) else $error("bad count or address executed"); // see R24

  property p_write_store;
    @(posedge clk_i) disable iff (!rst_b_i)
    cmd_o.valid && cmd_o.write |-> regs_ff[cmd_o.addr[$clog2(NUM_REGS)-1:0]] == cmd_o.data
      && reply_hdr_ff[`MDS_DATA_W-1:0] == cmd_o.data;
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored or echoed"); // see R22

  property p_reply_addr;
    @(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_EXEC |=> reply_hdr_ff[`MDS_HDR_W-2:`MDS_DATA_W] == $past(rx.addr);
  endproperty
  a_reply_addr: assert property (p_reply_addr) else $error("reply address not echoed"); // see R20

  property p_reply_load;
    @(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_IDLE && cs_fall |=> sreg_ff == $past(reply_frame) && sdo_o == $past(reply_frame[`MDS_FRAME_BITS-1]);
  endproperty
  a_reply_load: assert property (p_reply_load) else $error("reply not loaded at select fall"); // see R17

  c_read: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_o.valid && !cmd_o.write);
  c_write: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    cmd_o.valid && cmd_o.write);
  c_error: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_EXEC && !frame_good);
  c_chain: cover property (@(posedge clk_i) disable iff (!rst_b_i)
    state_ff == ST_EXEC && frame_good && cnt_ff == `MDS_CNT_W'(2 * `MDS_FRAME_BITS));

endmodule

`default_nettype wire

// ---- design/mds_unused.sv ----
// intentionally empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- test/mds_master_model.sv ----
// behavioural serial master that stands on the far side of the motor driver slave
`timescale 1ns/1ps
`default_nettype none

module mds_master_model (
  // timing reference
  input wire logic clk_i,
  // slave reply pins
  input wire logic sdo_i,
  input wire logic sdo_oe_i,
  // master driven pins
  output var logic sclk_o,
  output var logic chip_select_n_o,
  output var logic sdi_o
);
  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  initial begin
    sclk_o = 1'b0;
    chip_select_n_o = 1'b1;
    sdi_o = 1'b0;
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // ----------------------------------------------------------------
  // one select period of nb bits; reply bits collect lsb-aligned
  // ----------------------------------------------------------------
  task automatic xfer(input logic [319:0] tx, input int nb, output logic [319:0] rx);
    rx = '0;
    chip_select_n_o = 1'b0;
    tk(8);
    for (int i = 0; i < nb; i++) begin
      sclk_o = 1'b1;
      sdi_o = tx[nb-1-i];
      tk(4);
      sclk_o = 1'b0;
      // an undriven reply line is taken as unknown so it only matches an expected unknown
      rx = {rx[318:0], (sdo_oe_i === 1'b1) ? sdo_i : 1'bx};
      tk(4);
    end
    chip_select_n_o = 1'b1;
    // a released data line must not keep showing the last bit
    sdi_o = ~sdi_o;
    tk(8);
  endtask
endmodule

`default_nettype wire

// ---- test/mds_spi_slave_tb.sv ----
// self-checking bench for the motor driver serial slave
`timescale 1ns/1ps
`default_nettype none

module mds_spi_slave_tb;
  import mds_pkg::*;
  localparam logic [23:0] WD = 24'ha5c3e1;
  localparam logic [39:0] FULL = 40'hffffffffff;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sleep_n = 1'b1;
  wire logic sclk;
  wire logic chip_select_n;
  wire logic sdi;
  logic sdo;
  logic sdo_oe;
  logic osc_en;
  logic ferr;
  mds_cmd_s cmd;
  mds_cmd_s last_cmd = '0;
  int n_fail = 0;
  int n_tests = 0;
  int n_valid = 0;
  logic [319:0] rx;

  always #20 clk_i = ~clk_i;

  mds_spi_slave #(.NUM_REGS(16), .MAX_FRAMES(8)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sleep_control_n_i(sleep_n),
    .sclk_i(sclk), .chip_select_n_i(chip_select_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_o(sdo_oe), .internal_oscillator_en_o(osc_en),
    .cmd_o(cmd), .frame_err_o(ferr)
  );

  mds_master_model master (
    .clk_i(clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
    .sclk_o(sclk), .chip_select_n_o(chip_select_n), .sdi_o(sdi)
  );

  always @(posedge clk_i) begin
    if (cmd.valid === 1'b1) begin
      n_valid <= n_valid + 1;
      last_cmd <= cmd;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // builds a frame or a reply: top bit, address, data, crc over the top 32 bits
  function automatic logic [39:0] mk(input logic d, input logic [6:0] a, input logic [23:0] v);
    logic [31:0] h;
    logic [7:0] c;
    h = {d, a, v};
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ h[i]) == 1'b1) ? 8'h1d : 8'h00);
    end
    return {h, c};
  endfunction

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // runs one select period and checks reply, error level and accepted commands
  task automatic frame(input logic [79:0] tx, input int nb, input logic [39:0] rep, input logic [39:0] msk,
                       input logic err, input int nv);
    int nv0;
    nv0 = n_valid;
    master.xfer({240'h0, tx}, nb, rx);
    chk("reply", rx[nb-1 -: 40] & msk, rep & msk);
    chk("frame error", ferr, err);
    chk("command count", n_valid - nv0, nv);
    chk("output enable released", sdo_oe, 1'b0);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    close_out();
  end

  initial begin
    tk(10);
    rst_b_i = 1'b1;
    tk(3);
    chk("output enable idle", sdo_oe, 1'b0);
    chk("oscillator awake", osc_en, 1'b1);
    chk("command idle", cmd, '0);
    chk("error idle", ferr, 1'b0);
    // write, then read it back; each reply belongs to the frame before
    frame(mk(1'b1, 7'h03, WD), 40, 40'h0, FULL, 1'b0, 1);
    chk("write command", last_cmd, {1'b1, 1'b1, 7'h03, WD});
    frame(mk(1'b0, 7'h03, 24'h5a5a5a), 40, mk(1'b0, 7'h03, WD), FULL, 1'b0, 1);
    chk("read command", last_cmd, {1'b1, 1'b0, 7'h03, 24'h0});
    // corrupted checksum: reply still carries the read, nothing runs
    frame(mk(1'b0, 7'h03, 24'h0) ^ 40'h1, 40, mk(1'b0, 7'h03, WD), FULL, 1'b1, 0);
    frame(mk(1'b0, 7'h7f, 24'h0), 40, {1'b1, 7'h03, 32'h0}, 40'hff00000000, 1'b1, 0);
    // one clock short of a frame
    master.xfer({280'h0, mk(1'b0, 7'h03, 24'h0) >> 1}, 39, rx);
    chk("short reply head", rx[38:31], {1'b1, 7'h7f});
    chk("short frame error", ferr, 1'b1);
    // two frames in one select: the first passes through, the last is ours
    frame({mk(1'b1, 7'h05, 24'h123456), mk(1'b0, 7'h03, 24'h0)}, 80, 40'h8000000000, 40'h8000000000,
          1'b0, 1);
    chk("pass through", rx[39:0], mk(1'b1, 7'h05, 24'h123456));
    chk("chained command", last_cmd, {1'b1, 1'b0, 7'h03, 24'h0});
    frame(mk(1'b0, 7'h00, 24'h0), 40, mk(1'b0, 7'h03, WD), FULL, 1'b0, 1);
    // asleep the link is dead: no reply drive and the write is dropped
    sleep_n = 1'b0;
    tk(4);
    chk("oscillator asleep", osc_en, 1'b0);
    frame(mk(1'b1, 7'h03, 24'h0), 40, 40'hxxxxxxxxxx, FULL, 1'b0, 0);
    sleep_n = 1'b1;
    tk(8);
    frame(mk(1'b0, 7'h03, 24'h0), 40, 40'h0, FULL, 1'b0, 1);
    frame(mk(1'b0, 7'h00, 24'h0), 40, mk(1'b0, 7'h03, WD), FULL, 1'b0, 1);
    close_out();
  end
endmodule

`default_nettype wire
